// ### hw/lmcr_pkg.sv
// Purpose: shared constants of the LED matrix configuration register bank
// Assumes: byte-wide registers reached over a two-wire serial port
// Notes: offsets are the serial register addresses
package lmcr_pkg;
   // register addresses
   localparam logic [7:0] SCALE_BASE = 8'h92;
   localparam logic [7:0] SCALE_LAST = 8'h9F;
   localparam logic [7:0] MODE_ADDR = 8'hA0;
   localparam logic [7:0] GCC_ADDR = 8'hA1;
   localparam logic [7:0] PULL_ADDR = 8'hB0;
   // reset values
   localparam logic [7:0] SCALE_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h10;
   localparam logic [6:0] GCC_RST = 7'h00;
   localparam logic [7:0] PULL_RST = 8'h33;
   // field layout
   localparam int MODE_SHDN_BIT = 0;
   localparam int MODE_FD_LSB = 1;
   localparam int MODE_LGC_BIT = 3;
   localparam int MODE_ROW_LSB = 4;
   localparam int PULL_PHASE_BIT = 7;
   localparam int PULL_ROW_LSB = 4;
   localparam int PULL_COL_LSB = 0;
   localparam int PULL_ALWAYS_BIT = 2;
   localparam logic [7:0] PULL_WR_MASK = 8'hF7;
   localparam int GCC_W = 7;
   localparam logic [6:0] GCC_MAX = 7'h40;
   localparam int PEAK_W = 15;
   // codes
   localparam logic [1:0] FD_OFF = 2'h0;
   localparam logic [1:0] FD_SHORT = 2'h2;
   localparam logic [3:0] ROW_ALL_ON = 4'h8;
   localparam logic [3:0] ROW_COUNT_MAX = 4'h9;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int ROWS = 9;
   // serial port states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
   } lmcr_state_e;
endpackage

// ### hw/lmcr_regs.sv
// Purpose: configuration registers of an LED matrix driver behind a two-wire serial slave
// Assumes: scl_in and sda_in are already synchronous to clock; sda is open-drain
// Notes: the serial port writes and reads all registers with pointer auto increment
// How it works
// - one 8-bit scale per column sink
// - peak level is global level times scale
// - mode register: rows, threshold, fault, shutdown
// - shutdown release bit zero keeps software shutdown
// - fault code 01/11 fires one open pass
// - fault code 10 fires one short pass
// - row code picks scanned row count
// - global level clamps at 64
// - pull register top bit selects scan phase
// - row pull-down field off, off-time, always
// - column pull-up field off, off-time, always
// - pointer advances on each data byte, including a read byte the host does not acknowledge
`timescale 1ns/10ps
`default_nettype none
module lmcr_regs #(
   parameter int NUM_SINKS = 8,
   parameter logic [4:0] DEV_ADDR_HI = 5'h0D
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // serial port
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [1:0] addr_sel,
   // operating mode
   output logic shutdown_release,
   output logic logic_threshold_select,
   output logic [1:0] fault_detect_mode,
   output logic open_detect_start,
   output logic short_detect_start,
   // scan rows
   output logic [3:0] scan_row_select,
   output logic [3:0] active_row_count,
   output logic [lmcr_pkg::ROWS-1:0] row_switch_enable,
   output logic rows_all_on,
   output logic ninth_row_shared,
   // current
   output logic [lmcr_pkg::GCC_W-1:0] global_current_level,
   output logic [8*NUM_SINKS-1:0] sink_scale_value,
   output logic [lmcr_pkg::PEAK_W*NUM_SINKS-1:0] sink_peak_level,
   // pulls and phase
   output logic scan_phase_select,
   output logic [2:0] row_pulldown_select,
   output logic [2:0] column_pullup_select,
   output logic row_pulldown_always,
   output logic column_pullup_always
);
   import lmcr_pkg::*;

   if (NUM_SINKS < 1 || NUM_SINKS > 14) begin : g_chk
      $error("NUM_SINKS must lie in 1..14");
   end

   function automatic logic [3:0] row_count(input logic [3:0] code);
      logic [3:0] n;
      n = ROW_COUNT_MAX;
      if (code != 4'h0 && code < ROW_ALL_ON) begin
         n = ROW_COUNT_MAX - code;
      end
      return n;
   endfunction

   // serial port state
   lmcr_state_e st_q, st_d, after_q, after_d;
   logic scl_q, sda_q, oe_q, oe_d, nack_q, nack_d, wr_stb;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_byte;
   logic scl_rise, scl_fall, start_c, stop_c;

   // register state
   logic [7:0] mode_q, mode_d, pull_q, pull_d;
   logic [6:0] gcc_q, gcc_d;
   logic [7:0] scale_q [NUM_SINKS];
   logic [7:0] scale_d [NUM_SINKS];
   logic open_q, open_d, short_q, short_d;

   // derived outputs
   logic [3:0] rcnt_q, rcnt_d;
   logic [ROWS-1:0] rmask_q, rmask_d;

   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_c = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_c = scl_in & scl_q & ~sda_q & sda_in;

   always_comb begin
      rd_byte = 8'h00;
      if (ptr_q == MODE_ADDR) begin
         rd_byte = mode_q;
      end else if (ptr_q == GCC_ADDR) begin
         rd_byte = {1'b0, gcc_q};
      end else if (ptr_q == PULL_ADDR) begin
         rd_byte = pull_q;
      end
      for (int i = 0; i < NUM_SINKS; i++) begin
         if (ptr_q == SCALE_BASE + 8'(i)) begin
            rd_byte = scale_q[i];
         end
      end
   end

   always_comb begin
      st_d = st_q;
      after_d = after_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      nack_d = nack_q;
      wr_stb = 1'b0;
      if (start_c) begin
         st_d = ST_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop_c) begin
         st_d = ST_IDLE;
         oe_d = 1'b0;
      end else if (scl_rise) begin
         if (st_q == ST_ADDR || st_q == ST_REG || st_q == ST_WDATA) begin
            sh_d = {sh_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
         end else if (st_q == ST_MACK) begin
            nack_d = sda_in;
         end
      end else if (scl_fall) begin
         unique case (st_q)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (cnt_q == BYTE_BITS) begin
                  if (sh_q[7:1] == {DEV_ADDR_HI, addr_sel}) begin
                     oe_d = 1'b1;
                     st_d = ST_ACK;
                     after_d = sh_q[0] ? ST_RDATA : ST_REG;
                  end else begin
                     st_d = ST_IDLE;
                  end
               end
            end
            ST_REG: begin
               if (cnt_q == BYTE_BITS) begin
                  ptr_d = sh_q;
                  oe_d = 1'b1;
                  st_d = ST_ACK;
                  after_d = ST_WDATA;
               end
            end
            ST_WDATA: begin
               if (cnt_q == BYTE_BITS) begin
                  wr_stb = 1'b1;
                  ptr_d = ptr_q + 8'h01;
                  oe_d = 1'b1;
                  st_d = ST_ACK;
               end
            end
            ST_ACK: begin
               oe_d = 1'b0;
               cnt_d = 4'h0;
               st_d = after_q;
               if (after_q == ST_RDATA) begin
                  sh_d = rd_byte;
                  ptr_d = ptr_q + 8'h01;
                  oe_d = ~rd_byte[7];
                  cnt_d = 4'h1;
               end
            end
            ST_RDATA: begin
               if (cnt_q == BYTE_BITS) begin
                  oe_d = 1'b0;
                  st_d = ST_MACK;
               end else begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
                  cnt_d = cnt_q + 4'h1;
               end
            end
            ST_MACK: begin
               if (nack_q) begin
                  st_d = ST_IDLE;
               end else begin
                  sh_d = rd_byte;
                  ptr_d = ptr_q + 8'h01;
                  oe_d = ~rd_byte[7];
                  cnt_d = 4'h1;
                  st_d = ST_RDATA;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         after_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         oe_q <= 1'b0;
         nack_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         st_q <= st_d;
         after_q <= after_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         nack_q <= nack_d;
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // registers; the detect pulse fires only on a move away from 00 so a rewrite cannot re-trigger
   always_comb begin
      mode_d = mode_q;
      gcc_d = gcc_q;
      pull_d = pull_q;
      scale_d = scale_q;
      open_d = 1'b0;
      short_d = 1'b0;
      if (wr_stb) begin
         if (ptr_q == MODE_ADDR) begin
            mode_d = sh_q;
            if (mode_q[MODE_FD_LSB +: 2] == FD_OFF && sh_q[MODE_FD_LSB +: 2] != FD_OFF) begin
               open_d = sh_q[MODE_FD_LSB +: 2] != FD_SHORT;
               short_d = sh_q[MODE_FD_LSB +: 2] == FD_SHORT;
            end
         end else if (ptr_q == GCC_ADDR) begin
            gcc_d = (sh_q[6:0] > GCC_MAX) ? GCC_MAX : sh_q[6:0];
         end else if (ptr_q == PULL_ADDR) begin
            pull_d = sh_q & PULL_WR_MASK;
         end
         for (int i = 0; i < NUM_SINKS; i++) begin
            if (ptr_q == SCALE_BASE + 8'(i)) begin
               scale_d[i] = sh_q;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_q <= MODE_RST;
         gcc_q <= GCC_RST;
         pull_q <= PULL_RST;
         open_q <= 1'b0;
         short_q <= 1'b0;
         for (int i = 0; i < NUM_SINKS; i++) begin
            scale_q[i] <= SCALE_RST;
         end
      end else begin
         mode_q <= mode_d;
         gcc_q <= gcc_d;
         pull_q <= pull_d;
         open_q <= open_d;
         short_q <= short_d;
         scale_q <= scale_d;
      end
   end

   // row decode, one cycle behind the mode register
   always_comb begin
      rcnt_d = row_count(mode_q[MODE_ROW_LSB +: 4]);
      rmask_d = ROWS'((10'h001 << row_count(mode_q[MODE_ROW_LSB +: 4])) - 10'h001);
      if (mode_q[MODE_ROW_LSB +: 4] == ROW_ALL_ON) begin
         rmask_d = {ROWS{1'b1}};
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rcnt_q <= 4'h0;
         rmask_q <= '0;
      end else begin
         rcnt_q <= rcnt_d;
         rmask_q <= rmask_d;
      end
   end

   // peak level kept as the raw product; the analog side divides by 64 and 256
   for (genvar g = 0; g < NUM_SINKS; g++) begin : g_sink
      logic [PEAK_W-1:0] peak_q, peak_d;
      // widen both factors first; a cast of the bare product would keep only 8 bits
      assign peak_d = PEAK_W'(gcc_q) * PEAK_W'(scale_q[g]);
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            peak_q <= '0;
         end else begin
            peak_q <= peak_d;
         end
      end
      assign sink_peak_level[g*PEAK_W +: PEAK_W] = peak_q;
      assign sink_scale_value[g*8 +: 8] = scale_q[g];
      a_peak: assert property (@(posedge clock) disable iff (sys_rst)
         $past(gcc_q) == GCC_MAX && $past(scale_q[g]) == 8'hFF |-> peak_q == 15'h3FC0)
         else $error("peak level not product of level and scale");
   end

   assign sda_out = 1'b0;
   assign sda_oe = oe_q;
   assign shutdown_release = mode_q[MODE_SHDN_BIT];
   assign logic_threshold_select = mode_q[MODE_LGC_BIT];
   assign fault_detect_mode = mode_q[MODE_FD_LSB +: 2];
   assign open_detect_start = open_q;
   assign short_detect_start = short_q;
   assign scan_row_select = mode_q[MODE_ROW_LSB +: 4];
   assign active_row_count = rcnt_q;
   assign row_switch_enable = rmask_q;
   assign rows_all_on = mode_q[MODE_ROW_LSB +: 4] == ROW_ALL_ON;
   assign ninth_row_shared = rcnt_q == ROW_COUNT_MAX && !rows_all_on;
   assign global_current_level = gcc_q;
   assign scan_phase_select = pull_q[PULL_PHASE_BIT];
   assign row_pulldown_select = pull_q[PULL_ROW_LSB +: 3];
   assign column_pullup_select = pull_q[PULL_COL_LSB +: 3];
   assign row_pulldown_always = pull_q[PULL_ROW_LSB + PULL_ALWAYS_BIT];
   assign column_pullup_always = pull_q[PULL_COL_LSB + PULL_ALWAYS_BIT];

   a_gcc_clamp: assert property (@(posedge clock) disable iff (sys_rst)
      gcc_q <= GCC_MAX) else $error("global level above 64");
   a_gcc_write: assert property (@(posedge clock) disable iff (sys_rst)
      wr_stb && ptr_q == GCC_ADDR && sh_q[6:0] >= GCC_MAX |=> gcc_q == GCC_MAX)
      else $error("large level not clamped");
   a_open_once: assert property (@(posedge clock) disable iff (sys_rst)
      open_detect_start |-> $past(mode_q[MODE_FD_LSB +: 2]) == FD_OFF && fault_detect_mode[0])
      else $error("open pass without move from 00");
   a_short_once: assert property (@(posedge clock) disable iff (sys_rst)
      short_detect_start |-> $past(mode_q[MODE_FD_LSB +: 2]) == FD_OFF && fault_detect_mode == FD_SHORT)
      else $error("short pass without move from 00");
   a_ptr_inc: assert property (@(posedge clock) disable iff (sys_rst)
      wr_stb && !start_c |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer did not advance");
   a_row_eight: assert property (@(posedge clock) disable iff (sys_rst)
      scan_row_select == 4'h1 ##1 scan_row_select == 4'h1 |-> row_switch_enable == 9'h0FF)
      else $error("row code 1 not eight rows");
   a_row_all: assert property (@(posedge clock) disable iff (sys_rst)
      rows_all_on ##1 rows_all_on |-> row_switch_enable == 9'h1FF && active_row_count == 4'h9)
      else $error("all-on rows not all enabled");
   a_unused_zero: assert property (@(posedge clock) disable iff (sys_rst)
      pull_q[3] == 1'b0 && (ptr_q != GCC_ADDR || rd_byte[7] == 1'b0))
      else $error("unused bit not zero");
   a_shutdown: assert property (@(posedge clock) disable iff (sys_rst)
      wr_stb && ptr_q == MODE_ADDR |=> shutdown_release == $past(sh_q[0]))
      else $error("shutdown release not taken from write");
endmodule
`default_nettype wire

// ### test/lmcr_host.sv
// Purpose: two-wire bus master standing in for the host controller
// Assumes: device samples scl every clock; each bus phase lasts several clocks
// Notes: a released sda reads high through the pull-up, never the last value
`timescale 1ns/10ps
`default_nettype none
module lmcr_host (
   // bus
   input wire logic clock,
   output logic scl,
   output logic m_oe,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task hc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // data only moves while scl is low, so no false start or stop
   task bitx(input logic b, output logic r);
      scl = 1'b0;
      hc(1);
      m_oe = ~b;
      hc(2);
      scl = 1'b1;
      hc(4);
      r = sda;
   endtask
   task start;
      scl = 1'b0;
      hc(1);
      m_oe = 1'b0;
      hc(2);
      scl = 1'b1;
      hc(4);
      m_oe = 1'b1;
      hc(4);
   endtask
   task stop;
      scl = 1'b0;
      hc(1);
      m_oe = 1'b1;
      hc(2);
      scl = 1'b1;
      hc(4);
      m_oe = 1'b0;
      hc(4);
   endtask
   task wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(b[i], r);
      end
      bitx(1'b1, ack);
   endtask
   task rbyte(output logic [7:0] v, input logic nack);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bitx(1'b1, r);
         v = {v[6:0], r};
      end
      bitx(nack, r);
   endtask
endmodule
`default_nettype wire

// ### test/lmcr_regs_test.sv
// Purpose: self-checking bench of the LED matrix register bank
// Assumes: host model drives the bus; sda pulled up
// Notes: reference registers kept as a byte array, checked after every write
`timescale 1ns/10ps
`default_nettype none
module lmcr_regs_test;
   import lmcr_pkg::*;
   localparam logic [4:0] DEVHI = 5'h0D;
   logic clock, sys_rst, scl, m_oe, sda, sda_out, sda_oe, shutdown_release, logic_threshold_select;
   logic open_detect_start, short_detect_start, rows_all_on, ninth_row_shared, scan_phase_select;
   logic row_pulldown_always, column_pullup_always;
   logic [1:0] addr_sel, fault_detect_mode;
   logic [3:0] scan_row_select, active_row_count;
   logic [8:0] row_switch_enable;
   logic [6:0] global_current_level;
   logic [63:0] sink_scale_value;
   logic [119:0] sink_peak_level;
   logic [2:0] row_pulldown_select, column_pullup_select;
   int fails, n_tests, seed, e_open, e_short, n_open, n_short;
   logic [7:0] m [0:255];
   logic [7:0] q [$];
   assign sda = ~(m_oe | sda_oe);
   lmcr_host u_host (.clock(clock), .scl(scl), .m_oe(m_oe), .sda(sda));
   lmcr_regs #(.NUM_SINKS(8), .DEV_ADDR_HI(DEVHI)) DUT (.clock(clock), .sys_rst(sys_rst),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
      .shutdown_release(shutdown_release), .logic_threshold_select(logic_threshold_select),
      .fault_detect_mode(fault_detect_mode), .open_detect_start(open_detect_start),
      .short_detect_start(short_detect_start), .scan_row_select(scan_row_select),
      .active_row_count(active_row_count), .row_switch_enable(row_switch_enable),
      .rows_all_on(rows_all_on), .ninth_row_shared(ninth_row_shared),
      .global_current_level(global_current_level), .sink_scale_value(sink_scale_value),
      .sink_peak_level(sink_peak_level), .scan_phase_select(scan_phase_select),
      .row_pulldown_select(row_pulldown_select), .column_pullup_select(column_pullup_select),
      .row_pulldown_always(row_pulldown_always), .column_pullup_always(column_pullup_always));
   always @(posedge clock) begin
      if (open_detect_start === 1'b1)
         n_open++;
      if (short_detect_start === 1'b1)
         n_short++;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wrap_up;
      $display("compares %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task upd(input logic [7:0] a, input logic [7:0] d);
      if (a >= SCALE_BASE && a < SCALE_BASE + 8'h08)
         m[a] = d;
      if (a == MODE_ADDR && m[a][2:1] == FD_OFF && d[2:1] != FD_OFF) begin
         if (d[2:1] == FD_SHORT)
            e_short++;
         else
            e_open++;
      end
      if (a == MODE_ADDR)
         m[a] = d;
      if (a == GCC_ADDR)
         m[a] = (d[6:0] > GCC_MAX) ? {1'b0, GCC_MAX} : {1'b0, d[6:0]};
      if (a == PULL_ADDR)
         m[a] = d & PULL_WR_MASK;
   endtask
   task chk_out;
      logic [3:0] rc;
      logic [3:0] n;
      logic [7:0] p;
      rc = m[MODE_ADDR][7:4];
      p = m[PULL_ADDR];
      n = (rc == 4'h0 || rc >= 4'h8) ? 4'h9 : 4'h9 - rc;
      repeat (3) @(posedge clock);
      #1;
      chk(shutdown_release, m[MODE_ADDR][0]);
      chk({scan_row_select, logic_threshold_select, fault_detect_mode}, m[MODE_ADDR][7:1]);
      chk(active_row_count, n);
      chk(row_switch_enable, rc == 4'h8 ? 10'h1FF : (10'h001 << n) - 10'h001);
      chk(rows_all_on, rc == 4'h8);
      chk(global_current_level, m[GCC_ADDR]);
      chk(scan_phase_select, p[7]);
      chk({row_pulldown_select, row_pulldown_always}, {p[6:4], p[6]});
      chk({column_pullup_select, column_pullup_always}, {p[2:0], p[2]});
      for (int i = 0; i < 8; i++) begin
         chk(sink_scale_value[8*i+:8], m[SCALE_BASE + i]);
         chk(sink_peak_level[15*i+:15], m[GCC_ADDR] * m[SCALE_BASE + i]);
      end
      chk(n_open, e_open);
      chk(n_short, e_short);
   endtask
   task wr(input logic [7:0] a, input logic bad);
      logic k;
      logic [7:0] p;
      p = a;
      u_host.start;
      u_host.wbyte({DEVHI, addr_sel ^ {bad, bad}, 1'b0}, k);
      chk(k, bad);
      u_host.wbyte(a, k);
      foreach (q[i]) begin
         u_host.wbyte(q[i], k);
         if (!bad)
            upd(p, q[i]);
         p++;
      end
      u_host.stop;
      chk_out;
   endtask
   task w1(input logic [7:0] a, input logic [7:0] v);
      q = {v};
      wr(a, 1'b0);
   endtask
   task rd(input logic [7:0] a, input int n);
      logic k;
      logic [7:0] v;
      u_host.start;
      u_host.wbyte({DEVHI, addr_sel, 1'b0}, k);
      u_host.wbyte(a, k);
      u_host.start;
      u_host.wbyte({DEVHI, addr_sel, 1'b1}, k);
      chk(k, 1'b0);
      for (int i = 0; i < n; i++) begin
         u_host.rbyte(v, i == n - 1);
         chk(v, m[a + i]);
      end
      u_host.stop;
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clock);
      fails++;
      wrap_up;
   end
   initial begin
      seed = 36152;
      foreach (m[i]) m[i] = 8'h00;
      m[MODE_ADDR] = MODE_RST;
      m[PULL_ADDR] = PULL_RST;
      sys_rst = 1'b1;
      addr_sel = 2'b01;
      repeat (5) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      chk_out;
      rd(SCALE_BASE, 10);
      rd(MODE_ADDR, 2);
      rd(PULL_ADDR, 1);
      $display("reset values done");
      q = {};
      for (int i = 0; i < 10; i++) q.push_back(8'($random(seed)));
      wr(SCALE_BASE, 1'b0);
      rd(SCALE_BASE, 10);
      $display("scale burst done");
      q = {8'h7F, 8'hC5, 8'h40, 8'h41, 8'h3F, 8'($random(seed))};
      foreach (q[i]) begin
         w1(GCC_ADDR, q[i]);
         rd(GCC_ADDR, 1);
      end
      q = {8'h11, 8'hFF};
      wr(MODE_ADDR, 1'b0);
      $display("global level done");
      for (int c = 0; c < 16; c++) w1(MODE_ADDR, {c[3:0], c[1], 2'b00, c[0]});
      $display("row select done");
      w1(GCC_ADDR, 8'h01);
      q = {8'h01, 8'h01, 8'h00, 8'h03, 8'h02, 8'h00, 8'h02, 8'h02, 8'h00, 8'h01, 8'h02};
      foreach (q[i]) w1(MODE_ADDR, {4'h1, 1'b0, q[i][1:0], 1'b1});
      $display("fault detect done");
      q = {8'hFF, 8'h00, 8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
      foreach (q[i]) begin
         w1(PULL_ADDR, q[i]);
         rd(PULL_ADDR, 1);
      end
      q = {8'h22};
      wr(GCC_ADDR, 1'b1);
      $display("pulls and wrong address done");
      wrap_up;
   end
endmodule
`default_nettype wire
